// [logic/cma_ctrl.sv]
// Operation
// (R1) menu entry only on p plus e
// (R2) zero code goes straight to function select
// (R3) stored code shows code prompt first
// (R4) p clears prompt, arrows digit, p advances
// (R5) four digits then e opens menu
// (R6) wrong code or idle timeout returns display
// (R7) arrows scroll through menu functions
// (R8) data then save legends while storing
// (R9) reset values are the factory defaults
// (R10) resolution steps 1, 2, 5, 10
// (R11) decimal point any gap or off
// (R12) external source captures zero and span
// (R13) internal reference adjusts zero and span
// (R14) alarm entries only when alarms fitted
// (R15) held p shows percent or milliamps
// (R16) buttons synchronised, debounced, pairs detected
`timescale 1ns/10ps
`default_nettype none
`include "cma_cfg.svh"
module cma_ctrl #(
    parameter int         TICK_CYC  = `CMA_CLK_MHZ * `CMA_TICK_US,
    parameter logic [7:0] DEB_MS    = 8'(`CMA_DEB_MS),
    parameter int         IDLE_MS   = `CMA_IDLE_S * 1000,
    parameter int         LEGEND_MS = `CMA_LEGEND_MS
) (
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    // panel and measurement
    input  wire cma_pkg::cma_btn_t btn_raw,
    input  wire logic            alarm_fitted,
    input  wire logic [15:0]     adc_count,
    // register port
    input  wire logic [3:0]      addr,
    input  wire logic [31:0]     wdata,
    input  wire logic            wr,
    input  wire logic            rd,
    output logic [31:0]          rdata,
    // display and storage side
    output cma_pkg::cma_st_t     mode,
    output cma_pkg::cma_par_t    param,
    output logic [1:0]           digit,
    output logic [15:0]          code_entry,
    output logic                 show_pct,
    output logic                 show_ma,
    output cma_pkg::cma_set_t    settings,
    output logic [15:0]          zero_val,
    output logic [15:0]          span_val,
    output logic                 nvm_write
);
    import cma_pkg::*;

    localparam cma_set_t SET_DFLT = '{pct: 1'b1, tare: 1'b0,
        decimal_point_position: `CMA_DP_DFLT,
        display_resolution: CMA_RES_1, transfer_function_select: CMA_FN_LIN};

    // millisecond enable divider
    logic [17:0] div_reg, div_next;
    logic        tick;
    always_comb begin
        tick     = (div_reg == 18'(TICK_CYC - 1));
        div_next = tick ? '0 : div_reg + 18'h1;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) div_reg <= '0;
        else        div_reg <= div_next;
    end

    // per-button sync and debounce; a bounce restarts the hold count
    logic [3:0] deb;
    for (genvar i = 0; i < 4; i++) begin : g_deb
        logic s1_reg, s2_reg, db_reg, db_next;
        logic [7:0] dc_reg, dc_next;
        always_comb begin
            db_next = db_reg;
            dc_next = dc_reg;
            if (s2_reg == db_reg) begin
                dc_next = '0;
            end else if (tick) begin
                dc_next = dc_reg + 8'h1;
                if (dc_reg == DEB_MS - 8'h1) begin // [R16]
                    db_next = s2_reg;
                    dc_next = '0;
                end
            end
        end
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                db_reg <= 1'b0;
                dc_reg <= '0;
            end else begin
                s1_reg <= btn_raw[i]; // [R16]
                s2_reg <= s1_reg;
                db_reg <= db_next;
                dc_reg <= dc_next;
            end
        end
        assign deb[i] = db_reg;
    end

    // one decimal digit up or down, wrapping 9 to 0
    function automatic logic [15:0] bump(logic [15:0] v, logic [1:0] d, logic up);
        logic [3:0] n;
        n = v[{d, 2'b00} +: 4];
        if (up) n = (n == 4'h9) ? 4'h0 : n + 4'h1;
        else    n = (n == 4'h0) ? 4'h9 : n - 4'h1;
        v[{d, 2'b00} +: 4] = n;
        return v;
    endfunction : bump

    // next menu function, alarm slots skipped when not fitted
    function automatic cma_par_t step(cma_par_t p, logic fwd, logic al);
        cma_par_t n;
        if (fwd) n = (p == CMA_P_RST) ? CMA_P_TRANSFER_FUNCTION_SELECT : cma_par_t'(p + 4'h1);
        else     n = (p == CMA_P_TRANSFER_FUNCTION_SELECT) ? CMA_P_RST : cma_par_t'(p - 4'h1);
        if (!al && (n == CMA_P_AL1 || n == CMA_P_AL2)) // [R14]
            n = fwd ? CMA_P_PFN : CMA_P_BAR;
        return n;
    endfunction : step

    // main state
    cma_st_t    st_reg, st_next;
    cma_par_t   par_reg, par_next;
    logic [1:0] dig_reg, dig_next;
    logic [15:0] ent_reg, ent_next, code_reg, code_next;
    logic [15:0] zero_reg, zero_next, span_reg, span_next;
    cma_set_t   set_reg, set_next;
    logic [3:0] prev_reg;
    cma_btn_t   pr;          // press events
    logic       combo;       // p and e both down, one just now
    logic       sub_reg, sub_next, dirty_reg, dirty_next;
    logic       nvm_reg, nvm_next, shp_reg, shp_next, shm_reg, shm_next;
    logic [31:0] tmr_reg, tmr_next, rd_reg, rd_next;

    always_comb begin
        pr    = cma_btn_t'(deb & ~prev_reg);
        combo = deb[3] & deb[2] & ~(prev_reg[3] & prev_reg[2]); // [R16]
        st_next    = st_reg;
        par_next   = par_reg;
        dig_next   = dig_reg;
        ent_next   = ent_reg;
        code_next  = code_reg;
        zero_next  = zero_reg;
        span_next  = span_reg;
        set_next   = set_reg;
        sub_next   = sub_reg;
        dirty_next = dirty_reg;
        nvm_next   = 1'b0;
        rd_next    = '0;
        // register port, software view
        if (wr) begin
            unique case (addr)
                `CMA_A_SET:  set_next  = cma_set_t'(wdata[$bits(cma_set_t)-1:0]);
                `CMA_A_CODE: code_next = wdata[15:0];
                `CMA_A_CAL:  {span_next, zero_next} = wdata;
                default:     ;
            endcase
        end
        if (rd) begin
            unique case (addr)
                `CMA_A_SET:  rd_next = 32'(set_reg);
                `CMA_A_CODE: rd_next = 32'(code_reg);
                `CMA_A_CAL:  rd_next = {span_reg, zero_reg};
                `CMA_A_STAT: rd_next = 32'({dirty_reg, par_reg, dig_reg, st_reg});
                default:     rd_next = '0;
            endcase
        end
        unique case (st_reg)
            CMA_ST_DISP: if (combo) begin // [R1]
                par_next = CMA_P_TRANSFER_FUNCTION_SELECT;
                st_next  = (code_reg == `CMA_CODE_DFLT) ? CMA_ST_MENU // [R2]
                                                        : CMA_ST_PROMPT; // [R3]
            end
            CMA_ST_PROMPT: if (tmr_reg >= 32'(IDLE_MS)) begin
                st_next = CMA_ST_DISP; // [R6]
            end else if (pr.p) begin
                st_next  = CMA_ST_DIGIT; // [R4]
                dig_next = '0;
                ent_next = '0;
            end
            CMA_ST_DIGIT: if (tmr_reg >= 32'(IDLE_MS)) begin
                st_next = CMA_ST_DISP; // [R6]
            end else if (pr.e) begin
                // an unfinished entry counts as a wrong code
                if (dig_reg == `CMA_LAST_DIG && ent_reg == code_reg) begin
                    st_next  = CMA_ST_MENU; // [R5]
                    par_next = CMA_P_TRANSFER_FUNCTION_SELECT;
                end else begin
                    st_next = CMA_ST_DISP; // [R6]
                end
            end else if (pr.p) begin
                if (dig_reg != `CMA_LAST_DIG) dig_next = dig_reg + 2'h1; // [R4]
            end else if (pr.up || pr.dn) begin
                ent_next = bump(ent_reg, dig_reg, pr.up); // [R4]
            end
            CMA_ST_MENU: if (pr.up || pr.dn) begin
                par_next = step(par_reg, pr.up, alarm_fitted); // [R7]
            end else if (pr.p) begin
                st_next  = CMA_ST_EDIT;
                sub_next = 1'b0;
                dig_next = '0;
                ent_next = '0;
            end else if (pr.e) begin
                st_next = dirty_reg ? CMA_ST_DATA : CMA_ST_DISP; // [R8]
            end
            CMA_ST_EDIT: if (pr.e) begin
                st_next    = CMA_ST_MENU;
                dirty_next = 1'b1;
                if (par_reg == CMA_P_CODE) code_next = ent_reg;
                if (par_reg == CMA_P_RST) begin // [R9]
                    set_next  = SET_DFLT;
                    code_next = `CMA_CODE_DFLT;
                    zero_next = `CMA_ZERO_DFLT;
                    span_next = `CMA_SPAN_DFLT;
                end
            end else if (pr.p) begin
                sub_next = ~sub_reg;
                if (par_reg == CMA_P_CAL) begin // [R12]
                    if (sub_reg) span_next = adc_count;
                    else         zero_next = adc_count;
                end
                if (par_reg == CMA_P_CODE && dig_reg != `CMA_LAST_DIG)
                    dig_next = dig_reg + 2'h1;
            end else if (pr.up || pr.dn) begin
                unique case (par_reg)
                    CMA_P_TRANSFER_FUNCTION_SELECT: set_next.transfer_function_select =
                        (set_reg.transfer_function_select == CMA_FN_TABLE) ? CMA_FN_LIN
                        : cma_transfer_function_select_t'(set_reg.transfer_function_select + 2'h1);
                    CMA_P_DISPLAY_RESOLUTION: set_next.display_resolution = pr.up // [R10]
                        ? cma_res_t'(set_reg.display_resolution + 2'h1)
                        : cma_res_t'(set_reg.display_resolution - 2'h1);
                    CMA_P_DP: begin // [R11]
                        // up moves one gap on, down one gap back, both wrap through off
                        if (set_reg.decimal_point_position == (pr.up ? 3'h4 : 3'h0))
                            set_next.decimal_point_position = pr.up ? 3'h0 : 3'h4;
                        else
                            set_next.decimal_point_position = pr.up
                                ? set_reg.decimal_point_position + 3'h1
                                : set_reg.decimal_point_position - 3'h1;
                    end
                    CMA_P_SET: begin // [R13]
                        if (sub_reg) span_next = pr.up ? span_reg + 16'h1 : span_reg - 16'h1;
                        else         zero_next = pr.up ? zero_reg + 16'h1 : zero_reg - 16'h1;
                    end
                    CMA_P_PFN:  set_next.pct  = ~set_reg.pct;
                    CMA_P_TARE: set_next.tare = ~set_reg.tare;
                    CMA_P_CODE: ent_next = bump(ent_reg, dig_reg, pr.up);
                    default:    ;
                endcase
            end
            CMA_ST_DATA: if (tmr_reg >= 32'(LEGEND_MS)) begin
                st_next  = CMA_ST_SAVE; // [R8]
                nvm_next = 1'b1;
            end
            CMA_ST_SAVE: if (tmr_reg >= 32'(LEGEND_MS)) begin
                st_next    = CMA_ST_DISP;
                dirty_next = 1'b0;
            end
        endcase
        // one timer serves idle and legend; any press or move restarts it
        if (st_next != st_reg || pr != '0) tmr_next = '0;
        else if (tick)                     tmr_next = tmr_reg + 32'h1;
        else                               tmr_next = tmr_reg;
        shp_next = (st_reg == CMA_ST_DISP) && deb[3] && !deb[2] && set_reg.pct; // [R15]
        shm_next = (st_reg == CMA_ST_DISP) && deb[3] && !deb[2] && !set_reg.pct;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg    <= CMA_ST_DISP;
            par_reg   <= CMA_P_TRANSFER_FUNCTION_SELECT;
            dig_reg   <= '0;
            ent_reg   <= '0;
            code_reg  <= `CMA_CODE_DFLT; // [R9]
            zero_reg  <= `CMA_ZERO_DFLT;
            span_reg  <= `CMA_SPAN_DFLT;
            set_reg   <= SET_DFLT;
            prev_reg  <= '0;
            sub_reg   <= 1'b0;
            dirty_reg <= 1'b0;
            nvm_reg   <= 1'b0;
            shp_reg   <= 1'b0;
            shm_reg   <= 1'b0;
            tmr_reg   <= '0;
            rd_reg    <= '0;
        end else begin
            st_reg    <= st_next;
            par_reg   <= par_next;
            dig_reg   <= dig_next;
            ent_reg   <= ent_next;
            code_reg  <= code_next;
            zero_reg  <= zero_next;
            span_reg  <= span_next;
            set_reg   <= set_next;
            prev_reg  <= deb;
            sub_reg   <= sub_next;
            dirty_reg <= dirty_next;
            nvm_reg   <= nvm_next;
            shp_reg   <= shp_next;
            shm_reg   <= shm_next;
            tmr_reg   <= tmr_next;
            rd_reg    <= rd_next;
        end
    end

    assign rdata      = rd_reg;
    assign mode       = st_reg;
    assign param      = par_reg;
    assign digit      = dig_reg;
    assign code_entry = ent_reg;
    assign settings   = set_reg;
    assign zero_val   = zero_reg;
    assign span_val   = span_reg;
    assign show_pct   = shp_reg;
    assign show_ma    = shm_reg;
    assign nvm_write  = nvm_reg;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_entry_only_combo;
        st_reg == CMA_ST_DISP && !combo |=> st_reg inside {CMA_ST_DISP};
    endproperty
    a_entry_only_combo: assert property (p_entry_only_combo) else $error("menu entered without p+e"); // [R1]
    property p_zero_code;
        st_reg == CMA_ST_DISP && combo && code_reg == '0 |=> st_reg == CMA_ST_MENU && par_reg == CMA_P_TRANSFER_FUNCTION_SELECT;
    endproperty
    a_zero_code: assert property (p_zero_code) else $error("zero code did not open menu"); // [R2]
    property p_prompt;
        st_reg == CMA_ST_DISP && combo && code_reg != '0 |=> st_reg == CMA_ST_PROMPT;
    endproperty
    a_prompt: assert property (p_prompt) else $error("code prompt not shown"); // [R3]
    property p_clear;
        st_reg == CMA_ST_PROMPT && pr.p && tmr_reg < 32'(IDLE_MS) |=> st_reg == CMA_ST_DIGIT && dig_reg == '0 && ent_reg == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("prompt not cleared"); // [R4]
    property p_good_code;
        st_reg == CMA_ST_DIGIT && pr.e && tmr_reg < 32'(IDLE_MS) && dig_reg == 2'h3 && ent_reg == code_reg
            |=> st_reg == CMA_ST_MENU && par_reg == CMA_P_TRANSFER_FUNCTION_SELECT;
    endproperty
    a_good_code: assert property (p_good_code) else $error("good code refused"); // [R5]
    property p_idle;
        st_reg inside {CMA_ST_PROMPT, CMA_ST_DIGIT} |-> tmr_reg <= 32'(IDLE_MS);
    endproperty
    a_idle: assert property (p_idle) else $error("idle timeout overrun"); // [R6]
    property p_bad_code;
        st_reg == CMA_ST_DIGIT && pr.e && ent_reg != code_reg |=> st_reg == CMA_ST_DISP;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad code accepted"); // [R6]
    property p_scroll;
        st_reg == CMA_ST_MENU && (pr.up || pr.dn) |=> par_reg != $past(par_reg);
    endproperty
    a_scroll: assert property (p_scroll) else $error("menu did not scroll"); // [R7]
    property p_save;
        st_reg == CMA_ST_DATA ##1 st_reg == CMA_ST_SAVE |-> nvm_write ##1 !nvm_write;
    endproperty
    a_save: assert property (p_save) else $error("store pulse missing"); // [R8]
    property p_alarm;
        !alarm_fitted && st_reg == CMA_ST_MENU && (pr.up || pr.dn)
            |=> !(par_reg inside {CMA_P_AL1, CMA_P_AL2});
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm entry without alarms"); // [R14]
    c_code_ok: cover property (st_reg == CMA_ST_DIGIT ##1 st_reg == CMA_ST_MENU);
    c_saved:   cover property (st_reg == CMA_ST_SAVE ##1 st_reg == CMA_ST_DISP);
    c_timeout: cover property (st_reg == CMA_ST_PROMPT && tmr_reg >= 32'(IDLE_MS));
endmodule : cma_ctrl
`default_nettype wire

// [logic/cma_cfg.svh]
`ifndef CMA_CFG_SVH
`define CMA_CFG_SVH
// clock and time base
`define CMA_CLK_MHZ    200
`define CMA_TICK_US    1000
// times in their own units
`define CMA_DEB_MS     20
`define CMA_IDLE_S     20
`define CMA_LEGEND_MS  1000
// register offsets (byte addresses)
`define CMA_A_SET      4'h0
`define CMA_A_CODE     4'h4
`define CMA_A_CAL      4'h8
`define CMA_A_STAT     4'hc
// reset values and last code digit
`define CMA_CODE_DFLT  16'h0000
`define CMA_ZERO_DFLT  16'h0000
`define CMA_SPAN_DFLT  16'h03e8
`define CMA_DP_DFLT    3'h1
`define CMA_LAST_DIG   2'h3
`endif

// [logic/cma_pkg.sv]
`default_nettype none
package cma_pkg;
    // transfer function choice
    typedef enum logic [1:0] {CMA_FN_LIN, CMA_FN_ROOT, CMA_FN_TABLE} cma_transfer_function_select_t;
    // display_resolution: step of 1, 2, 5 or 10 counts
    typedef enum logic [1:0] {CMA_RES_1, CMA_RES_2, CMA_RES_5, CMA_RES_10} cma_res_t;
    // stored settings, field order fixes the register layout
    typedef struct packed {
        logic      pct;                    // p button shows percent, else mA
        logic      tare;                   // tare enabled
        logic [2:0] decimal_point_position; // 0 off, 1..4 gap index
        cma_res_t  display_resolution;
        cma_transfer_function_select_t transfer_function_select;
    } cma_set_t;
    // menu functions in scroll order
    typedef enum logic [3:0] {
        CMA_P_TRANSFER_FUNCTION_SELECT, CMA_P_DISPLAY_RESOLUTION, CMA_P_DP, CMA_P_CAL, CMA_P_SET, CMA_P_BAR,
        CMA_P_AL1, CMA_P_AL2, CMA_P_PFN, CMA_P_TARE, CMA_P_CODE, CMA_P_RST
    } cma_par_t;
    // operating states, also the shown legend
    typedef enum logic [2:0] {
        CMA_ST_DISP, CMA_ST_PROMPT, CMA_ST_DIGIT, CMA_ST_MENU,
        CMA_ST_EDIT, CMA_ST_DATA, CMA_ST_SAVE
    } cma_st_t;
    // the four front panel buttons
    typedef struct packed {
        logic p;
        logic e;
        logic up;
        logic dn;
    } cma_btn_t;
endpackage : cma_pkg
`default_nettype wire

// [verif/cma_op_model.sv]
`timescale 1ns/10ps
`default_nettype none
// operator at the front panel: four push-buttons, active high
module cma_op_model import cma_pkg::*; #(
    parameter int HOLD = 24    // cycles a settled level is kept
) (
    // clock
    input  wire logic          clk_sys,
    // panel
    output var cma_btn_t       btn_raw
);
    import cma_pkg::*;

    // all buttons up at power-on
    initial btn_raw = '0;

    // press with contact chatter; real contacts never close cleanly
    task automatic down(input cma_btn_t b);
        @(posedge clk_sys);
        btn_raw <= b;
        @(posedge clk_sys);
        btn_raw <= '0;    // bounce
        @(posedge clk_sys);
        btn_raw <= b;
    endtask : down

    // let go of everything, then stay idle long enough to settle
    task automatic lift;
        @(posedge clk_sys);
        btn_raw <= '0;
        repeat (HOLD) @(posedge clk_sys);
    endtask : lift
endmodule : cma_op_model
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cma_cfg.svh"
module tb_top;
    import cma_pkg::*;
    localparam int       HOLD = 24;    // press length, beats debounce
    localparam cma_btn_t BP   = 4'h8;  // single buttons
    localparam cma_btn_t BE   = 4'h4;
    localparam cma_btn_t BU   = 4'h2;
    localparam cma_btn_t BD   = 4'h1;
    // dut signals
    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    cma_btn_t    btn_raw;
    logic        alarm_fitted = 1'b0;
    logic [15:0] adc_count    = 16'h0123;
    logic [3:0]  addr  = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [31:0] rdata;
    cma_st_t     mode;
    cma_par_t    param;
    logic [1:0]  digit;
    logic [15:0] code_entry;
    logic        show_pct;
    logic        show_ma;
    cma_set_t    settings;
    logic [15:0] zero_val;
    logic [15:0] span_val;
    logic        nvm_write;
    // bookkeeping
    int          mismatches = 0;
    int          cmp_count  = 0;
    int          nvm_cnt    = 0;
    logic [31:0] rv;

    // short counts keep the run small
    cma_ctrl #(.TICK_CYC(4), .DEB_MS(8'd2), .IDLE_MS(50), .LEGEND_MS(5)) cma_ctrl_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .btn_raw(btn_raw), .alarm_fitted(alarm_fitted),
        .adc_count(adc_count), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .mode(mode), .param(param), .digit(digit), .code_entry(code_entry),
        .show_pct(show_pct), .show_ma(show_ma), .settings(settings),
        .zero_val(zero_val), .span_val(span_val), .nvm_write(nvm_write));
    cma_op_model #(.HOLD(HOLD)) cma_op_model_i (.clk_sys(clk_sys), .btn_raw(btn_raw));

    // 200 mhz
    initial forever #2.5 clk_sys = ~clk_sys;
    // count store strobes
    always @(posedge clk_sys) if (nvm_write === 1'b1) nvm_cnt <= nvm_cnt + 1;

    task automatic end_sim;
        $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask : bus_wr

    // data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : bus_rd

    // bounded wait; running out ends the run
    task automatic wait_mode(input cma_st_t m, input int lim);
        int n;
        n = 0;
        while (mode !== m && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= lim) begin
            mismatches++;
            end_sim();
        end
    endtask : wait_mode

    task automatic tap(input cma_btn_t b);
        cma_op_model_i.down(b);
        repeat (HOLD) @(posedge clk_sys);
        cma_op_model_i.lift();
    endtask : tap

    // factory values after reset, unmapped write ignored
    task automatic t_defaults;
        cma_set_t s;
        s = '{1'b1, 1'b0, `CMA_DP_DFLT, CMA_RES_1, CMA_FN_LIN};
        bus_wr(4'h2, 32'hffff_ffff);
        bus_rd(`CMA_A_SET, rv);
        chk(rv, {23'h0, s});
        bus_rd(`CMA_A_CODE, rv);
        chk(rv, 32'h0);
        bus_rd(`CMA_A_CAL, rv);
        chk(rv, {`CMA_SPAN_DFLT, `CMA_ZERO_DFLT});
        bus_rd(4'h2, rv);
        chk(rv, 32'h0);
    endtask : t_defaults

    // p alone shows percent while held, never opens the menu
    task automatic t_hold_p;
        cma_op_model_i.down(BP);
        repeat (HOLD) @(posedge clk_sys);
        chk({show_pct, show_ma}, 32'h2);
        chk(32'(mode), 32'(CMA_ST_DISP));
        cma_op_model_i.lift();
        chk({show_pct, show_ma}, 32'h0);
    endtask : t_hold_p

    // scroll order, alarm slots only when fitted
    task automatic t_scroll;
        cma_par_t e;
        e = CMA_P_TRANSFER_FUNCTION_SELECT;
        tap(BP | BE);
        chk(32'(mode), 32'(CMA_ST_MENU));
        for (int i = 0; i < 10; i++) begin
            tap(BU);
            e = e.next();
            if (e == CMA_P_AL1) e = CMA_P_PFN;
            chk(32'(param), 32'(e));
        end
        alarm_fitted <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            tap(BD);
            e = e.prev();
            chk(32'(param), 32'(e));
        end
        tap(BE);
        wait_mode(CMA_ST_DISP, 200);
    endtask : t_scroll

    // edit resolution to 10 and point off, then store legends
    task automatic t_edit;
        int n0;
        tap(BP | BE);
        tap(BU);
        tap(BP);
        chk(32'(mode), 32'(CMA_ST_EDIT));
        repeat (3) tap(BU);
        tap(BE);
        chk(32'(settings.display_resolution), 32'(CMA_RES_10));
        tap(BU);
        tap(BP);
        tap(BD);
        tap(BE);
        chk(32'(settings.decimal_point_position), 32'h0);
        n0 = nvm_cnt;
        cma_op_model_i.down(BE);
        wait_mode(CMA_ST_DATA, 60);
        chk(32'(mode), 32'(CMA_ST_DATA));
        wait_mode(CMA_ST_SAVE, 60);
        wait_mode(CMA_ST_DISP, 60);
        chk(nvm_cnt - n0, 32'h1);
        cma_op_model_i.lift();
    endtask : t_edit

    // capture zero and span from the input, then nudge zero by one
    task automatic t_cal;
        tap(BP | BE);
        repeat (3) tap(BU);
        tap(BP);
        tap(BP);
        chk(32'(zero_val), 32'h0123);
        adc_count <= 16'h0456;
        tap(BP);
        chk(32'(span_val), 32'h0456);
        tap(BE);
        tap(BU);
        tap(BP);
        tap(BU);
        tap(BE);
        chk(32'(zero_val), 32'h0124);
        tap(BE);
        wait_mode(CMA_ST_DISP, 200);
        bus_rd(`CMA_A_CAL, rv);
        chk(rv, 32'h0456_0124);
    endtask : t_cal

    // stored code 0091: prompt, digits, match, mismatch, idle
    task automatic t_code;
        bus_wr(`CMA_A_CODE, 32'h0000_0091);
        tap(BP | BE);
        chk(32'(mode), 32'(CMA_ST_PROMPT));
        tap(BP);
        chk({digit, code_entry}, 32'h0);
        tap(BU);
        tap(BP);
        tap(BD);
        chk({digit, code_entry}, 32'h1_0091);
        tap(BP);
        tap(BP);
        tap(BE);
        chk(32'(mode), 32'(CMA_ST_MENU));
        chk(32'(param), 32'(CMA_P_TRANSFER_FUNCTION_SELECT));
        tap(BE);
        wait_mode(CMA_ST_DISP, 200);
        tap(BP | BE);
        repeat (4) tap(BP);
        tap(BE);
        chk(32'(mode), 32'(CMA_ST_DISP));
        tap(BP | BE);
        repeat (120) @(posedge clk_sys);
        chk(32'(mode), 32'(CMA_ST_PROMPT));
        wait_mode(CMA_ST_DISP, 120);
        chk(32'(mode), 32'(CMA_ST_DISP));
    endtask : t_code

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (40) @(posedge clk_sys);
        t_defaults();
        t_hold_p();
        t_scroll();
        t_edit();
        t_cal();
        t_code();
        end_sim();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        mismatches++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
